//--- src/fuse_prog_pkg.sv
// Purpose: constants for the fuse store and parallel programming port
// Assumes: fuses active low (0 = programmed)
// Notes: offsets are byte selects and command codes
package fuse_prog_pkg;
	// =====================================
	// fuse defaults
	localparam logic [7:0] EXT_FUSE_RESET  = 8'hFF;
	localparam logic [7:0] HIGH_FUSE_RESET = 8'h99;
	localparam logic [7:0] LOW_FUSE_RESET  = 8'h62;
	localparam logic [7:0] LOCK_RESET      = 8'hFF;
	localparam logic [3:0] CLK_SRC_RC8     = 4'h2;
	localparam int         LOCK_FIRST_BIT  = 0;
	localparam int         SERIAL_DL_BIT   = 5;
	localparam int         PRESERVE_BIT    = 3;
	// =====================================
	// action codes
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	// =====================================
	// byte selects
	localparam logic [1:0] SEL_LOW  = 2'h0;
	localparam logic [1:0] SEL_HIGH = 2'h1;
	localparam logic [1:0] SEL_EXT  = 2'h2;
	localparam logic [1:0] SEL_TOP  = 2'h3;
	// =====================================
	// command bytes
	localparam logic [7:0] CMD_ERASE   = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK = 8'h20;
	localparam logic [7:0] CMD_WR_FL   = 8'h10;
	localparam logic [7:0] CMD_WR_EE   = 8'h11;
	localparam logic [7:0] CMD_RD_SIG  = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE = 8'h04;
	localparam logic [7:0] CMD_RD_FL   = 8'h02;
	localparam logic [7:0] CMD_RD_EE   = 8'h03;
	// =====================================
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int STROBE_MIN_NS = 250;
	localparam int STROBE_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_CYCLES   = 16;
	// =====================================
	// page geometry and state encoding
	localparam int FL_WORD_BITS_SMALL = 6;
	localparam int FL_WORD_BITS_LARGE = 7;
	localparam int EE_BYTE_BITS_SMALL = 2;
	localparam int EE_BYTE_BITS_LARGE = 3;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_BUSY  = 2'b01,
		ST_ERASE = 2'b10
	} prog_state_e;
endpackage

//--- src/fuse_prog_port.sv
// Purpose: fuse store, signature space, page buffers and parallel port
// Assumes: pins synchronous to clk; strobes held at least STROBE_CYCLES
// Notes: nonvolatile arrays modelled as registers
`timescale 1ns/1ns
module fuse_prog_port #(
	parameter int        FL_WORD_BITS = 6,
	parameter int        EE_BYTE_BITS = 2,
	parameter logic [7:0] SIG0 = 8'hA5,
	parameter logic [7:0] SIG1 = 8'h5A,
	parameter logic [7:0] SIG2 = 8'h3C,
	parameter logic [7:0] CAL_VALUE = 8'h80
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       prog_mode,
	input  wire logic       serial_mode,
	input  wire logic       crystal_input_strobe,
	input  wire logic       strobe_action_b0,
	input  wire logic       strobe_action_b1,
	input  wire logic       byte_select_lo,
	input  wire logic       byte_select_hi,
	input  wire logic       write_n,
	input  wire logic       output_enable_n,
	input  wire logic       page_buffer_load,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe_n,
	output logic            ready_busy_out,
	output logic      [7:0] low_fuse_active,
	output logic      [7:0] high_fuse_active,
	output logic      [7:0] ext_fuse_active,
	output logic            eeprom_preserve_on_erase,
	output logic      [7:0] oscillator_trim_register,
	output logic            erase_pulse
);
	// =====================================
	// state
	logic [7:0] low_config_fuses, high_config_fuses, extended_config_fuses, lock_bits;
	logic [7:0] next_low, next_high, next_ext, next_lock;
	logic [7:0] cmd, addr_lo, addr_hi, addr_ext, data_lo, data_hi;
	logic [7:0] next_cmd, next_addr_lo, next_addr_hi, next_addr_ext, next_data_lo, next_data_hi;
	logic [15:0] page_buf [0:(1<<FL_WORD_BITS)-1];
	logic [7:0]  ee_buf   [0:(1<<EE_BYTE_BITS)-1];
	logic       xs_d, wr_d, pl_d, pm_d;
	logic       xs_rise, wr_fall, pl_rise, pm_rise, pm_fall;
	fuse_prog_pkg::prog_state_e state, next_state;
	logic [7:0] busy_cnt, next_busy_cnt;
	logic [7:0] next_data_out, next_low_act, next_high_act, next_ext_act, next_trim;
	logic       next_oe_n, next_rdy, next_preserve, next_erase;
	logic [1:0] act, bsel;
	logic       fuse_lock;

	assign act       = {strobe_action_b1, strobe_action_b0};
	assign bsel      = {byte_select_hi, byte_select_lo};
	assign xs_rise   = crystal_input_strobe & ~xs_d;
	assign wr_fall   = ~write_n & wr_d;
	assign pl_rise   = page_buffer_load & ~pl_d;
	assign pm_rise   = prog_mode & ~pm_d;
	assign pm_fall   = ~prog_mode & pm_d;
	assign fuse_lock = ~lock_bits[fuse_prog_pkg::LOCK_FIRST_BIT];

	// =====================================
	// fuse read mux
	function automatic logic [7:0] fuse_read(input logic [1:0] s, input logic ser);
		logic [7:0] v;
		v = 8'hFF;
		case (s)
			fuse_prog_pkg::SEL_LOW:  v = low_config_fuses;
			fuse_prog_pkg::SEL_HIGH: v = lock_bits;
			fuse_prog_pkg::SEL_EXT:  v = extended_config_fuses;
			default: begin
				v = high_config_fuses;
				if (ser)
					v[fuse_prog_pkg::SERIAL_DL_BIT] = 1'b1;
			end
		endcase
		return v;
	endfunction

	// =====================================
	// command and write logic
	always_comb begin
		next_low      = low_config_fuses;
		next_high     = high_config_fuses;
		next_ext      = extended_config_fuses;
		next_lock     = lock_bits;
		next_cmd      = cmd;
		next_addr_lo  = addr_lo;
		next_addr_hi  = addr_hi;
		next_addr_ext = addr_ext;
		next_data_lo  = data_lo;
		next_data_hi  = data_hi;
		next_state    = state;
		next_busy_cnt = busy_cnt;
		next_erase    = 1'b0;
		if (prog_mode && state == fuse_prog_pkg::ST_IDLE && xs_rise) begin
			unique case (act)
				fuse_prog_pkg::ACT_ADDR: begin
					if (bsel == fuse_prog_pkg::SEL_LOW)
						next_addr_lo = data_in;
					else if (bsel == fuse_prog_pkg::SEL_HIGH)
						next_addr_hi = data_in;
					else if (bsel == fuse_prog_pkg::SEL_EXT)
						next_addr_ext = data_in;
				end
				fuse_prog_pkg::ACT_DATA: begin
					if (byte_select_lo)
						next_data_hi = data_in;
					else
						next_data_lo = data_in;
				end
				fuse_prog_pkg::ACT_CMD: next_cmd = data_in;
				default: ;
			endcase
		end
		if (prog_mode && state == fuse_prog_pkg::ST_IDLE && wr_fall) begin
			next_state    = fuse_prog_pkg::ST_BUSY;
			next_busy_cnt = 8'(fuse_prog_pkg::BUSY_CYCLES);
			case (cmd)
				fuse_prog_pkg::CMD_ERASE: begin
					next_lock  = fuse_prog_pkg::LOCK_RESET;
					next_erase = 1'b1;
					next_state = fuse_prog_pkg::ST_ERASE;
				end
				fuse_prog_pkg::CMD_WR_FUSE: begin
					if (!fuse_lock) begin
						if (bsel == fuse_prog_pkg::SEL_LOW)
							next_low = data_lo;
						else if (bsel == fuse_prog_pkg::SEL_HIGH) begin
							next_high = data_lo;
							if (serial_mode)
								next_high[fuse_prog_pkg::SERIAL_DL_BIT] =
									high_config_fuses[fuse_prog_pkg::SERIAL_DL_BIT];
						end else if (bsel == fuse_prog_pkg::SEL_EXT)
							next_ext = {5'h1F, data_lo[2:0]};
					end
				end
				fuse_prog_pkg::CMD_WR_LOCK: next_lock = lock_bits & data_lo;
				default: ;
			endcase
		end else if (state != fuse_prog_pkg::ST_IDLE) begin
			if (busy_cnt == 8'h00)
				next_state = fuse_prog_pkg::ST_IDLE;
			else
				next_busy_cnt = busy_cnt - 8'h01;
		end
	end

	// =====================================
	// page buffer fill
	always_ff @(posedge clk) begin
		if (prog_mode && pl_rise) begin
			if (cmd == fuse_prog_pkg::CMD_WR_FL)
				page_buf[addr_lo[FL_WORD_BITS-1:0]] <= {data_hi, data_lo};
			else if (cmd == fuse_prog_pkg::CMD_WR_EE)
				ee_buf[addr_lo[EE_BYTE_BITS-1:0]] <= data_lo;
		end
	end

	// =====================================
	// read path and shadows
	always_comb begin
		next_oe_n     = output_enable_n | ~prog_mode;
		next_data_out = 8'h00;
		if (cmd == fuse_prog_pkg::CMD_RD_SIG) begin
			if (byte_select_lo)
				next_data_out = CAL_VALUE;
			else if (addr_lo[1:0] == 2'h0)
				next_data_out = SIG0;
			else if (addr_lo[1:0] == 2'h1)
				next_data_out = SIG1;
			else
				next_data_out = SIG2;
		end else if (cmd == fuse_prog_pkg::CMD_RD_FUSE)
			next_data_out = fuse_read(bsel, serial_mode);
		else if (cmd == fuse_prog_pkg::CMD_RD_FL)
			next_data_out = byte_select_lo ? page_buf[addr_lo[FL_WORD_BITS-1:0]][15:8]
				: page_buf[addr_lo[FL_WORD_BITS-1:0]][7:0];
		else if (cmd == fuse_prog_pkg::CMD_RD_EE)
			next_data_out = ee_buf[addr_lo[EE_BYTE_BITS-1:0]];
		next_rdy      = (next_state == fuse_prog_pkg::ST_IDLE);
		next_low_act  = low_fuse_active;
		next_high_act = high_fuse_active;
		next_ext_act  = ext_fuse_active;
		if (pm_rise || pm_fall) begin
			next_low_act  = low_config_fuses;
			next_high_act = high_config_fuses;
			next_ext_act  = extended_config_fuses;
		end
		next_preserve = ~high_config_fuses[fuse_prog_pkg::PRESERVE_BIT];
		next_trim     = oscillator_trim_register;
	end

	// =====================================
	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			low_config_fuses         <= fuse_prog_pkg::LOW_FUSE_RESET;
			high_config_fuses        <= fuse_prog_pkg::HIGH_FUSE_RESET;
			extended_config_fuses    <= fuse_prog_pkg::EXT_FUSE_RESET;
			lock_bits                <= fuse_prog_pkg::LOCK_RESET;
			cmd                      <= 8'h00;
			addr_lo                  <= 8'h00;
			addr_hi                  <= 8'h00;
			addr_ext                 <= 8'h00;
			data_lo                  <= 8'hFF;
			data_hi                  <= 8'hFF;
			state                    <= fuse_prog_pkg::ST_IDLE;
			busy_cnt                 <= 8'h00;
			xs_d                     <= 1'b0;
			wr_d                     <= 1'b1;
			pl_d                     <= 1'b0;
			pm_d                     <= 1'b0;
			data_out                 <= 8'h00;
			data_oe_n                <= 1'b1;
			ready_busy_out           <= 1'b1;
			low_fuse_active          <= fuse_prog_pkg::LOW_FUSE_RESET;
			high_fuse_active         <= fuse_prog_pkg::HIGH_FUSE_RESET;
			ext_fuse_active          <= fuse_prog_pkg::EXT_FUSE_RESET;
			eeprom_preserve_on_erase <= 1'b0;
			oscillator_trim_register <= CAL_VALUE;
			erase_pulse              <= 1'b0;
		end else begin
			low_config_fuses         <= next_low;
			high_config_fuses        <= next_high;
			extended_config_fuses    <= next_ext;
			lock_bits                <= next_lock;
			cmd                      <= next_cmd;
			addr_lo                  <= next_addr_lo;
			addr_hi                  <= next_addr_hi;
			addr_ext                 <= next_addr_ext;
			data_lo                  <= next_data_lo;
			data_hi                  <= next_data_hi;
			state                    <= next_state;
			busy_cnt                 <= next_busy_cnt;
			xs_d                     <= crystal_input_strobe;
			wr_d                     <= write_n;
			pl_d                     <= page_buffer_load;
			pm_d                     <= prog_mode;
			data_out                 <= next_data_out;
			data_oe_n                <= next_oe_n;
			ready_busy_out           <= next_rdy;
			low_fuse_active          <= next_low_act;
			high_fuse_active         <= next_high_act;
			ext_fuse_active          <= next_ext_act;
			eeprom_preserve_on_erase <= next_preserve;
			oscillator_trim_register <= next_trim;
			erase_pulse              <= next_erase;
		end
	end

	// =====================================
	// checks
	busy_after_wr_a: assert property (@(posedge clk) disable iff (rst)
		(prog_mode && state == fuse_prog_pkg::ST_IDLE && wr_fall) |=> !ready_busy_out)
		else $error("ready not low after write strobe");
	erase_keeps_fuse_a: assert property (@(posedge clk) disable iff (rst)
		(state == fuse_prog_pkg::ST_IDLE && wr_fall && cmd == fuse_prog_pkg::CMD_ERASE)
		|=> $stable(low_config_fuses) && $stable(high_config_fuses))
		else $error("erase changed fuses");
	locked_fuse_a: assert property (@(posedge clk) disable iff (rst)
		fuse_lock |=> $stable(low_config_fuses))
		else $error("fuse changed while locked");
	oe_drive_a: assert property (@(posedge clk) disable iff (rst)
		!data_oe_n |-> $past(!output_enable_n))
		else $error("bus driven without output enable");
	ext_top_ones_a: assert property (@(posedge clk) disable iff (rst)
		extended_config_fuses[7:3] == 5'h1F)
		else $error("extended unused bits not one");
	shadow_hold_a: assert property (@(posedge clk) disable iff (rst)
		(prog_mode && $past(prog_mode)) |-> $stable(low_fuse_active))
		else $error("shadow changed inside programming");
	cmd_load_a: assert property (@(posedge clk) disable iff (rst)
		(prog_mode && state == fuse_prog_pkg::ST_IDLE && xs_rise && act == fuse_prog_pkg::ACT_CMD)
		|=> cmd == $past(data_in))
		else $error("command not loaded");
	preserve_now_a: assert property (@(posedge clk) disable iff (rst)
		$changed(high_config_fuses[fuse_prog_pkg::PRESERVE_BIT])
		|=> eeprom_preserve_on_erase != high_config_fuses[fuse_prog_pkg::PRESERVE_BIT])
		else $error("preserve fuse not immediate");
	erase_cov: cover property (@(posedge clk) erase_pulse);
	fuse_wr_cov: cover property (@(posedge clk) $changed(low_config_fuses));
	read_cov: cover property (@(posedge clk) !data_oe_n);
endmodule

//--- bench/par_programmer.sv
// Purpose: parallel programmer model driving the fuse port pins
// Assumes: pins change 1 ns after a clock edge
// Notes: a released data bus shows the inverse of its last value
`timescale 1ns/1ns
module par_programmer (
	input  wire logic       clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe_n,
	input  wire logic       ready_busy_out,
	output logic            crystal_input_strobe,
	output logic            strobe_action_b0,
	output logic            strobe_action_b1,
	output logic            byte_select_lo,
	output logic            byte_select_hi,
	output logic            write_n,
	output logic            output_enable_n,
	output logic            page_buffer_load,
	output logic      [7:0] data_in
);
	// ==========
	// pin tasks
	localparam int HOLD = fuse_prog_pkg::STROBE_CYCLES;
	initial begin
		{crystal_input_strobe, strobe_action_b1, strobe_action_b0} = 3'h3;
		{byte_select_hi, byte_select_lo, page_buffer_load} = 3'h0;
		{write_n, output_enable_n} = 2'h3;
		data_in = 8'hFF;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic xload(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
		{strobe_action_b1, strobe_action_b0} = act;
		{byte_select_hi, byte_select_lo} = bs;
		data_in = d;
		step(2);
		crystal_input_strobe = 1'b1;
		step(HOLD);
		crystal_input_strobe = 1'b0;
		step(4);
	endtask
	task automatic pgl();
		page_buffer_load = 1'b1;
		step(HOLD);
		page_buffer_load = 1'b0;
		step(4);
	endtask
	task automatic wr(input logic [1:0] bs, output logic busy);
		{byte_select_hi, byte_select_lo} = bs;
		step(2);
		write_n = 1'b0;
		step(2);
		busy = ~ready_busy_out;
		step(HOLD);
		write_n = 1'b1;
		for (int i = 0; i < 100 && ready_busy_out !== 1'b1; i++) step(1);
		busy = busy & ready_busy_out;
	endtask
	task automatic rd(input logic [1:0] bs, output logic [8:0] q);
		{byte_select_hi, byte_select_lo} = bs;
		data_in = ~data_in;
		step(2);
		output_enable_n = 1'b0;
		step(3);
		q = {data_oe_n, data_out};
		step(HOLD);
		output_enable_n = 1'b1;
		step(4);
	endtask
endmodule

//--- bench/fuse_signature_parallel_prog_port_tb.sv
// Purpose: self-checking bench for the fuse programming port
// Assumes: programmer model keeps strobe widths and holds
// Notes: reference fuse image kept in ints, random values from xorshift
`timescale 1ns/1ns
module fuse_signature_parallel_prog_port_tb;
	localparam logic [7:0] SIG [4] = '{8'h11, 8'h22, 8'h33, 8'h80}; // arbitrary, last is cal default
	localparam logic [1:0] RSEL [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
	logic       clk, rst, prog_mode, serial_mode, doen, rdy, pres, erp;
	logic       xs, a0, a1, bl, bh, wn, oen, pl;
	logic [7:0] din, dout, low_a, high_a, ext_a, trim;
	int         m [4];
	int         n_mismatch, total_checks, n_erase;
	logic [31:0] seed = 32'h309E;
	fuse_prog_port #(.SIG0(SIG[0]), .SIG1(SIG[1]), .SIG2(SIG[2])) i_dut (
		.clk(clk), .rst(rst), .prog_mode(prog_mode), .serial_mode(serial_mode),
		.crystal_input_strobe(xs), .strobe_action_b0(a0), .strobe_action_b1(a1),
		.byte_select_lo(bl), .byte_select_hi(bh), .write_n(wn), .output_enable_n(oen),
		.page_buffer_load(pl), .data_in(din), .data_out(dout), .data_oe_n(doen),
		.ready_busy_out(rdy), .low_fuse_active(low_a), .high_fuse_active(high_a),
		.ext_fuse_active(ext_a), .eeprom_preserve_on_erase(pres),
		.oscillator_trim_register(trim), .erase_pulse(erp));
	par_programmer p (
		.clk(clk), .data_out(dout), .data_oe_n(doen), .ready_busy_out(rdy),
		.crystal_input_strobe(xs), .strobe_action_b0(a0), .strobe_action_b1(a1),
		.byte_select_lo(bl), .byte_select_hi(bh), .write_n(wn), .output_enable_n(oen),
		.page_buffer_load(pl), .data_in(din));
	// ==========
	// helpers
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) if (erp === 1'b1) n_erase++;
	function automatic logic [31:0] xs32(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(input logic ok, input string what);
		total_checks++;
		if (!ok) begin
			n_mismatch++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	task automatic fw(input int i, input logic [7:0] v);
		logic b;
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_WR_FUSE);
		p.xload(fuse_prog_pkg::ACT_DATA, 2'h0, v);
		p.wr(i[1:0], b);
		if (m[3][0]) chk(b === 1'b1, "busy handshake");
		if (i == 1 && serial_mode) v[5] = m[1][5];
		if (i == 2) v[7:3] = 5'h1F;
		if (m[3][0]) m[i] = v;
	endtask
	task automatic cf(input string what);
		logic [8:0] q;
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_RD_FUSE);
		p.xload(2'h3, 2'h0, 8'h00);
		for (int i = 0; i < 4; i++) begin
			p.rd(RSEL[i], q);
			chk(q === {1'b0, m[i][7:0]} && doen === 1'b1, what);
		end
	endtask
	task automatic ca();
		chk(low_a === m[0][7:0] && high_a === m[1][7:0] && ext_a === m[2][7:0], "actives");
		chk(pres === ~m[1][3], "preserve flag");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#(4 * 40000);
		n_mismatch++;
		print_verdict();
	end
	// ==========
	// scenarios
	initial begin
		logic [8:0] q;
		logic       b;
		rst = 1'b1;
		prog_mode = 1'b0;
		serial_mode = 1'b0;
		m = '{32'h62, 32'h99, 32'hFF, 32'hFF};
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		p.step(2);
		ca();
		chk(low_a[3:0] === fuse_prog_pkg::CLK_SRC_RC8, "clock source");
		chk(trim === SIG[3] && rdy === 1'b1 && doen === 1'b1, "reset state");
		prog_mode = 1'b1;
		p.step(4);
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_RD_SIG);
		for (int i = 0; i < 4; i++) begin
			p.xload(fuse_prog_pkg::ACT_ADDR, fuse_prog_pkg::SEL_LOW, 8'(i % 3));
			p.rd({1'b0, i == 3}, q);
			chk(q === {1'b0, SIG[i]}, "signature read");
		end
		fw(0, 8'hFE);
		fw(1, 8'h91);
		chk(pres === 1'b1, "preserve immediate");
		chk(low_a === 8'h62 && high_a === 8'h99, "actives held");
		for (int k = 0; k < 3; k++) begin
			seed = xs32(seed);
			fw(2, seed[7:0]);
		end
		cf("fuse readback");
		serial_mode = 1'b1;
		fw(1, 8'hB1);
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_RD_FUSE);
		p.rd(fuse_prog_pkg::SEL_TOP, q);
		chk(q === {1'b0, m[1][7:0] | 8'h20}, "download bit hidden");
		serial_mode = 1'b0;
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_ERASE);
		p.wr(2'h0, b);
		chk(b === 1'b1 && n_erase == 1, "chip erase");
		cf("fuses after erase");
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_WR_FL);
		p.xload(fuse_prog_pkg::ACT_ADDR, fuse_prog_pkg::SEL_LOW, 8'h45);
		p.xload(fuse_prog_pkg::ACT_DATA, fuse_prog_pkg::SEL_LOW, 8'h12);
		p.xload(fuse_prog_pkg::ACT_DATA, fuse_prog_pkg::SEL_HIGH, 8'h34);
		p.pgl();
		p.wr(2'h0, b);
		chk(b === 1'b1, "flash page write");
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_RD_FL);
		p.xload(fuse_prog_pkg::ACT_ADDR, fuse_prog_pkg::SEL_LOW, 8'h05);
		p.rd(fuse_prog_pkg::SEL_LOW, q);
		chk(q === 9'h012, "flash low byte");
		p.rd(fuse_prog_pkg::SEL_HIGH, q);
		chk(q === 9'h034, "flash high byte");
		seed = xs32(seed);
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_WR_EE);
		p.xload(fuse_prog_pkg::ACT_ADDR, fuse_prog_pkg::SEL_LOW, 8'h06);
		p.xload(fuse_prog_pkg::ACT_DATA, fuse_prog_pkg::SEL_LOW, seed[7:0]);
		p.pgl();
		p.wr(2'h0, b);
		chk(b === 1'b1, "eeprom page write");
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_RD_EE);
		p.xload(fuse_prog_pkg::ACT_ADDR, fuse_prog_pkg::SEL_LOW, 8'h0A);
		p.rd(fuse_prog_pkg::SEL_LOW, q);
		chk(q === {1'b0, seed[7:0]}, "eeprom byte");
		prog_mode = 1'b0;
		p.step(4);
		ca();
		prog_mode = 1'b1;
		p.step(4);
		p.xload(fuse_prog_pkg::ACT_CMD, 2'h0, fuse_prog_pkg::CMD_WR_LOCK);
		p.xload(fuse_prog_pkg::ACT_DATA, 2'h0, 8'hFE);
		p.wr(2'h0, b);
		m[3] = 32'hFE;
		fw(0, 8'h00);
		cf("locked fuses");
		rst = 1'b1;
		prog_mode = 1'b0;
		p.step(3);
		rst = 1'b0;
		m = '{32'h62, 32'h99, 32'hFF, 32'hFF};
		p.step(2);
		ca();
		chk(trim === SIG[3], "trim after reset");
		print_verdict();
	end
endmodule
